//--- verilog/aab_regs.sv
`timescale 1ns/100ps
// Summary of operation
// RULE_01: pause bit only travels in the advertised word; it steers nothing else.
// RULE_02: advertisement bits 9:5 are writable and choose which abilities are sent.
// RULE_03: reset restores advertisement defaults; reads return the last written value.
// RULE_04: advertised selector bits 4:0 always hold 00001.
// RULE_05: partner ability register is read-only, resets to zero, mirrors the partner word.
// RULE_06: manager trusts partner ability only after negotiation complete reads one.
// RULE_07: partner next page bit is copied to bit 15 and otherwise ignored.
// RULE_08: partner remote fault is copied to bit 13 and otherwise ignored.
// RULE_09: partner acknowledge is shown in bit 14.
// RULE_10: partner ability bits 9:5 clear on negotiation restart and on reset.
// RULE_11: partner selector bits 4:0 clear on negotiation restart and on reset.
// RULE_12: expansion bit 4 latches parallel detection fault until read or reset.
// RULE_13: expansion bit 3 always equals partner ability bit 15.
// RULE_14: expansion bit 2 always reads one.
// RULE_15: expansion bit 1 latches page received until read or reset.
// RULE_16: expansion bit 0 shows partner negotiation ability, zero before exchange.
// RULE_17: manager writes reserved bits with defaults and ignores them on read.
// RULE_18: negotiation complete reads one only when partner contents are valid.
// RULE_19: advertisement sits at address 04h, pause bit 10, defaults one on 8:5.
// RULE_20: clear-on-read happens after the read; a coinciding event stays latched.
module aab_regs (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // management register port, decoded from the serial frames
  input wire logic mgmt_wr,
  input wire logic mgmt_rd,
  input wire logic [4:0] mgmt_addr,
  input wire logic [15:0] mgmt_wdata,
  output logic [15:0] mgmt_rdata,
  // negotiation engine events
  input wire logic an_restart,
  input wire logic page_rx,
  input wire logic [15:0] page_word,
  input wire logic par_fault,
  input wire logic partner_not_an,
  input wire logic an_done_in,
  // toward the negotiation engine and status register
  output logic [15:0] adv_word,
  output logic an_complete
);
  logic [15:0] adv_ff;
  logic [15:0] nxt_adv;
  logic [15:0] lp_ff;
  logic [15:0] nxt_lp;
  logic lp_valid_ff;
  logic nxt_lp_valid;
  logic lpan_ff;
  logic nxt_lpan;
  logic [15:0] rdata_ff;
  logic [15:0] nxt_rdata;
  logic [15:0] adv_view;
  logic [15:0] exp_view;
  logic rd_exp;

  // two latched flags live in the keeper; a set beats the clearing read there
  aab_flag_if #(.N(aab_pkg::NUM_FLAGS)) flg ();

  aab_sticky_flags #(.N(aab_pkg::NUM_FLAGS)) u_flags (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .flg(flg)
  );

  // advertisement writes; only the documented bits take data
  // reserved and selector bits are dropped here, so a careless write cannot disturb them
  always_comb begin
    nxt_adv = adv_ff;
    if (mgmt_wr && mgmt_addr == aab_pkg::ADDR_ADV) begin // RULE_19
      nxt_adv = mgmt_wdata & aab_pkg::ADV_WR_MASK; // RULE_02
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      adv_ff <= aab_pkg::ADV_RESET; // RULE_03
    end else begin
      adv_ff <= nxt_adv;
    end
  end

  // word sent to the partner; selector is wired, not stored, so it cannot drift
  // the same view feeds the read path, so what is sent is what is read back
  always_comb begin
    adv_view = adv_ff & aab_pkg::ADV_WR_MASK;
    adv_view[4:0] = aab_pkg::SELECTOR_8023; // RULE_04
  end
  // pause reaches the engine only inside this word
  assign adv_word = adv_view; // RULE_01

  // partner page capture; restart beats a page arriving in the same cycle
  // a page that loses to a restart is simply dropped; the engine sends it again
  always_comb begin
    nxt_lp = lp_ff;
    nxt_lp_valid = lp_valid_ff;
    nxt_lpan = lpan_ff;
    if (an_restart) begin
      nxt_lp = aab_pkg::LP_RESET; // RULE_10 RULE_11
      nxt_lp_valid = 1'b0;
      nxt_lpan = 1'b0; // RULE_16
    end else begin
      if (page_rx) begin
        // np, ack and fault bits are copied verbatim; only np is used again, for expansion bit 3
        nxt_lp = page_word & aab_pkg::LP_KEEP_MASK; // RULE_05 RULE_07 RULE_08 RULE_09
        nxt_lp_valid = 1'b1;
        nxt_lpan = 1'b1; // RULE_16
      end
      if (partner_not_an) begin
        nxt_lpan = 1'b0; // RULE_16
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lp_ff <= aab_pkg::LP_RESET; // RULE_05
      lp_valid_ff <= 1'b0;
      lpan_ff <= 1'b0;
    end else begin
      lp_ff <= nxt_lp;
      lp_valid_ff <= nxt_lp_valid;
      lpan_ff <= nxt_lpan;
    end
  end

  // complete is withheld until a partner page has been captured
  assign an_complete = an_done_in & lp_valid_ff; // RULE_18

  // latched flag events and clear-on-read of the expansion register
  // the page flag survives a restart on purpose: only a read or reset drops it
  assign rd_exp = mgmt_rd && mgmt_addr == aab_pkg::ADDR_EXP;
  assign flg.set[aab_pkg::FLAG_PAGE] = page_rx & ~an_restart; // RULE_15
  assign flg.set[aab_pkg::FLAG_FAULT] = par_fault; // RULE_12
  assign flg.clr = {aab_pkg::NUM_FLAGS{rd_exp}}; // RULE_20

  // expansion view; reserved bits read zero
  // built from live state, so bit 3 can never disagree with partner bit 15
  always_comb begin
    exp_view = 16'h0000; // RULE_17
    exp_view[aab_pkg::EXP_FAULT_BIT] = flg.val[aab_pkg::FLAG_FAULT]; // RULE_12
    exp_view[aab_pkg::EXP_LPNP_BIT] = lp_ff[aab_pkg::ADV_NP_BIT]; // RULE_13
    exp_view[aab_pkg::EXP_NPABLE_BIT] = 1'b1; // RULE_14
    exp_view[aab_pkg::EXP_PAGE_BIT] = flg.val[aab_pkg::FLAG_PAGE]; // RULE_15
    exp_view[aab_pkg::EXP_LPAN_BIT] = lpan_ff; // RULE_16
  end

  // read data sampled on the same edge the flags clear, so the read sees them;
  // the word is registered and stands until the next read, which lets a slow
  // serial frame shift it out without a second copy
  always_comb begin
    nxt_rdata = rdata_ff;
    if (mgmt_rd) begin
      case (mgmt_addr)
        aab_pkg::ADDR_ADV: nxt_rdata = adv_view; // RULE_03
        aab_pkg::ADDR_LP: nxt_rdata = lp_ff; // RULE_05
        aab_pkg::ADDR_EXP: nxt_rdata = exp_view; // RULE_20
        default: nxt_rdata = 16'h0000; // other addresses belong elsewhere
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= aab_pkg::RDATA_RESET;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign mgmt_rdata = rdata_ff;

  // checks of the register behaviour
  // engine inputs are treated as free, so every check must hold for any
  // ordering of pages, restarts, faults and reads
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sel_const_a: assert property (adv_word[4:0] == 5'h01) // RULE_04
    else $error("selector not 00001");
  adv_write_a: assert property (mgmt_wr && mgmt_addr == 5'h04 |=> // RULE_02
      adv_word[9:5] == $past(mgmt_wdata[9:5]))
    else $error("ability bits did not take write");
  adv_readback_a: assert property (mgmt_rd && mgmt_addr == 5'h04 && !mgmt_wr |=> // RULE_03
      mgmt_rdata == adv_word)
    else $error("advertisement readback wrong");
  pause_word_a: assert property (mgmt_wr && mgmt_addr == 5'h04 |=> // RULE_01
      adv_word[10] == $past(mgmt_wdata[10]))
    else $error("pause bit not carried");
  lp_clear_a: assert property (an_restart |=> lp_ff[9:0] == 10'h000) // RULE_10
    else $error("partner abilities not cleared on restart");
  lp_capture_a: assert property (page_rx && !an_restart |=> // RULE_05
      lp_ff == ($past(page_word) & 16'hE7FF))
    else $error("partner word not captured");
  exp_lpnp_a: assert property (exp_view[3] == lp_ff[15]) // RULE_13
    else $error("expansion next page mismatch");
  exp_npable_a: assert property (exp_view[2]) // RULE_14
    else $error("next page able not one");
  fault_latch_a: assert property (par_fault |=> exp_view[4] until rd_exp) // RULE_12
    else $error("fault flag not held");
  page_hold_a: assert property (rd_exp && page_rx && !an_restart |=> exp_view[1]) // RULE_15
    else $error("page flag lost on coinciding read");
  read_clear_a: assert property (rd_exp && exp_view[1] && !page_rx |=> // RULE_20
      mgmt_rdata[1] && !exp_view[1])
    else $error("read did not return then clear");
  lpan_clear_a: assert property (an_restart |=> !exp_view[0]) // RULE_16
    else $error("partner able not cleared");
  complete_a: assert property (an_complete |-> lp_valid_ff) // RULE_18
    else $error("complete without valid partner page");

  // advertisement: reserved bits stay zero and a written value holds
  // until the next write to 04h; reads return the wired selector
  adv_resv_a: assert property (adv_word[14] == 1'b0 && adv_word[12:11] == 2'h0) // RULE_02
    else $error("reserved advertisement bits not zero");
  adv_hold_a: assert property (!(mgmt_wr && mgmt_addr == 5'h04) |=> // RULE_03
      $stable(adv_word))
    else $error("advertisement changed without a write");
  adv_upper_a: assert property (mgmt_wr && mgmt_addr == 5'h04 |=> // RULE_03
      adv_word[15] == $past(mgmt_wdata[15]) && adv_word[13] == $past(mgmt_wdata[13]))
    else $error("next page or fault bit did not take write");
  adv_read_a: assert property (mgmt_rd && mgmt_addr == 5'h04 |=> // RULE_19
      mgmt_rdata == $past(adv_word))
    else $error("address 04h did not return the advertisement");
  sel_read_a: assert property (mgmt_rd && mgmt_addr == 5'h04 |=> // RULE_04
      mgmt_rdata[4:0] == 5'h01)
    else $error("selector read back wrong");

  // partner word: every copied bit lands in its place, and nothing
  // but a page, a restart or reset moves it
  lp_hold_a: assert property (!page_rx && !an_restart |=> $stable(lp_ff)) // RULE_05
    else $error("partner word changed without a page");
  lp_np_a: assert property (page_rx && !an_restart |=> // RULE_07
      lp_ff[15] == $past(page_word[15]))
    else $error("partner next page bit not copied");
  lp_ack_a: assert property (page_rx && !an_restart |=> // RULE_09
      lp_ff[14] == $past(page_word[14]))
    else $error("partner acknowledge bit not copied");
  lp_fault_a: assert property (page_rx && !an_restart |=> // RULE_08
      lp_ff[13] == $past(page_word[13]))
    else $error("partner remote fault bit not copied");
  lp_abil_a: assert property (page_rx && !an_restart |=> // RULE_10
      lp_ff[10:5] == $past(page_word[10:5]))
    else $error("partner abilities not copied");
  lp_sel_a: assert property (page_rx && !an_restart |=> // RULE_11
      lp_ff[4:0] == $past(page_word[4:0]))
    else $error("partner selector not copied");
  lp_resv_a: assert property (lp_ff[12:11] == 2'h0) // RULE_05
    else $error("partner reserved bits not zero");
  lp_sel_clear_a: assert property (an_restart |=> lp_ff[4:0] == 5'h00) // RULE_11
    else $error("partner selector not cleared on restart");
  lp_read_a: assert property (mgmt_rd && mgmt_addr == 5'h05 |=> // RULE_05
      mgmt_rdata == $past(lp_ff))
    else $error("address 05h did not return the partner word");

  // expansion flags: set by events, held between reads, returned by the
  // read that clears them
  page_set_a: assert property (page_rx && !an_restart |=> exp_view[1]) // RULE_15
    else $error("page received flag not set");
  page_keep_a: assert property (exp_view[1] && !rd_exp |=> exp_view[1]) // RULE_15
    else $error("page received flag dropped without a read");
  page_clear_a: assert property (rd_exp && !page_rx |=> !exp_view[1]) // RULE_15
    else $error("page received flag not cleared by read");
  fault_hold_a: assert property (exp_view[4] && !rd_exp |=> exp_view[4]) // RULE_12
    else $error("fault flag dropped without a read");
  fault_clear_a: assert property (rd_exp && !par_fault |=> !exp_view[4]) // RULE_12
    else $error("fault flag not cleared by read");
  fault_read_a: assert property (rd_exp && exp_view[4] |=> mgmt_rdata[4]) // RULE_20
    else $error("fault flag cleared before it was returned");
  lpan_set_a: assert property (page_rx && !an_restart && !partner_not_an |=> // RULE_16
      exp_view[0])
    else $error("partner able not set by a page");
  lpan_hold_a: assert property (exp_view[0] && !an_restart && !partner_not_an |=> // RULE_16
      exp_view[0])
    else $error("partner able dropped without cause");
  lpan_drop_a: assert property (partner_not_an |=> !exp_view[0]) // RULE_16
    else $error("partner able not dropped");
  exp_read_a: assert property (rd_exp |=> mgmt_rdata[3:0] == $past(exp_view[3:0])) // RULE_13
    else $error("expansion read returned wrong low bits");

  // read port and completion: data stands between reads, complete
  // follows the engine only while a captured page is valid
  rdata_hold_a: assert property (!mgmt_rd |=> $stable(mgmt_rdata)) // RULE_03
    else $error("read data moved without a read");
  rdata_unmapped_a: assert property ( // RULE_17
      mgmt_rd && !(mgmt_addr inside {5'h04, 5'h05, 5'h06}) |=> mgmt_rdata == 16'h0000)
    else $error("unmapped address returned data");
  complete_gate_a: assert property (!an_done_in |-> !an_complete) // RULE_18
    else $error("complete without the engine finishing");
  complete_restart_a: assert property (an_restart |=> !an_complete) // RULE_18
    else $error("complete survived a restart");
  lp_valid_a: assert property (page_rx && !an_restart |=> lp_valid_ff) // RULE_18
    else $error("captured page not marked valid");

  // scenarios worth seeing: coinciding events, restarts, refused partners
  page_cov_c: cover property (page_rx ##[1:8] rd_exp);
  fault_cov_c: cover property (par_fault && rd_exp);
  restart_cov_c: cover property (page_rx ##1 an_restart);
  lpan_drop_c: cover property (page_rx ##[1:8] partner_not_an);
  clash_cov_c: cover property (rd_exp && page_rx && par_fault);
endmodule // aab_regs

//--- verilog/aab_pkg.sv
package aab_pkg;
  // management register addresses of this bank
  localparam logic [4:0] ADDR_ADV = 5'h04;
  localparam logic [4:0] ADDR_LP = 5'h05;
  localparam logic [4:0] ADDR_EXP = 5'h06;
  // advertisement field positions
  localparam int ADV_NP_BIT = 15;
  localparam int ADV_RF_BIT = 13;
  localparam int ADV_PAUSE_BIT = 10;
  localparam int ABIL_HI = 9;
  localparam int ABIL_LO = 5;
  // writable advertisement bits: 15, 13, 10, 9:5
  localparam logic [15:0] ADV_WR_MASK = 16'hA7E0;
  // reset values: abilities 8:5 set, everything else clear
  localparam logic [15:0] ADV_RESET = 16'h01E0;
  // 802.3 selector, constant in bits 4:0
  localparam logic [4:0] SELECTOR_8023 = 5'h01;
  // partner word bits kept: all but reserved 12:11
  localparam logic [15:0] LP_KEEP_MASK = 16'hE7FF;
  localparam logic [15:0] LP_RESET = 16'h0000;
  // expansion bit positions
  localparam int EXP_FAULT_BIT = 4;
  localparam int EXP_LPNP_BIT = 3;
  localparam int EXP_NPABLE_BIT = 2;
  localparam int EXP_PAGE_BIT = 1;
  localparam int EXP_LPAN_BIT = 0;
  // latched flag slots inside the flag keeper
  localparam int FLAG_PAGE = 0;
  localparam int FLAG_FAULT = 1;
  localparam int NUM_FLAGS = 2;
  localparam logic [15:0] RDATA_RESET = 16'h0000;
endpackage

//--- verilog/aab_flag_if.sv
`timescale 1ns/100ps
interface aab_flag_if #(parameter int N = 2);
  logic [N-1:0] set;
  logic [N-1:0] clr;
  logic [N-1:0] val;
  modport owner (output set, output clr, input val);
  modport keeper (input set, input clr, output val);
endinterface // aab_flag_if

//--- verilog/aab_sticky_flags.sv
`timescale 1ns/100ps
module aab_sticky_flags #(
  parameter int N = 2
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // flag control
  aab_flag_if.keeper flg
);
  logic [N-1:0] flag_ff;
  logic [N-1:0] nxt_flag;

  // one latch per flag; a set in the clearing cycle wins so no event is lost
  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_flag
      always_comb begin
        nxt_flag[gi] = flg.set[gi] | (flag_ff[gi] & ~flg.clr[gi]); // RULE_20
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flag_ff <= '0;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  assign flg.val = flag_ff;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  set_wins_a: assert property (flg.set[0] |=> flag_ff[0]) // RULE_20
    else $error("flag 0 set was lost");
  clr_only_a: assert property (flg.clr[0] && !flg.set[0] |=> !flag_ff[0]) // RULE_15
    else $error("flag 0 not cleared by read");
endmodule // aab_sticky_flags

//--- testbench/aab_mgmt_model.sv
`timescale 1ns/100ps
module aab_mgmt_model (
  // clock
  input wire logic clk_sys,
  // register port toward the device
  output logic mgmt_wr,
  output logic mgmt_rd,
  output logic [4:0] mgmt_addr,
  output logic [15:0] mgmt_wdata,
  input wire logic [15:0] mgmt_rdata
);
  // idle port at time zero
  initial begin
    mgmt_wr = 1'b0;
    mgmt_rd = 1'b0;
    mgmt_addr = 5'h1F;
    mgmt_wdata = 16'h0000;
  end
  // one strobe, held one edge; released lines get inverted values, not the old ones
  task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d,
      output logic [15:0] q);
    @(posedge clk_sys) #1;
    mgmt_wr = w;
    mgmt_rd = !w;
    mgmt_addr = a;
    mgmt_wdata = d;
    @(posedge clk_sys) #1;
    q = mgmt_rdata;
    mgmt_wr = 1'b0;
    mgmt_rd = 1'b0;
    mgmt_addr = ~a;
    mgmt_wdata = ~d;
  endtask
  // reserved and selector bits go back as read
  task automatic rmw(input logic [4:0] a, input logic [15:0] d);
    logic [15:0] old;
    acc(1'b0, a, 16'h0000, old);
    acc(1'b1, a, (old & 16'h581F) | (d & ~16'h581F), old);
  endtask
endmodule // aab_mgmt_model

//--- testbench/autoneg_ability_registers_test.sv
`timescale 1ns/100ps
`define CHK(g, e) begin \
  compares++; \
  if ((g) !== (e)) begin \
    fails++; \
    $display("wrong value at %0t: got %h want %h", $time, g, e); \
  end \
end
module autoneg_ability_registers_test;
  logic clk_sys, rst_n, mgmt_wr, mgmt_rd, an_restart, page_rx, par_fault;
  logic partner_not_an, an_done_in, an_complete;
  logic [4:0] mgmt_addr;
  logic [15:0] mgmt_wdata, mgmt_rdata, page_word, adv_word, q;
  int fails = 0;
  int compares = 0;
  aab_regs uut (.clk_sys(clk_sys), .rst_n(rst_n), .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd),
    .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
    .an_restart(an_restart), .page_rx(page_rx), .page_word(page_word),
    .par_fault(par_fault), .partner_not_an(partner_not_an), .an_done_in(an_done_in),
    .adv_word(adv_word), .an_complete(an_complete));
  aab_mgmt_model mdl (.clk_sys(clk_sys), .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd),
    .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata));
  // 40 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic rd(input logic [4:0] a);
    mdl.acc(1'b0, a, 16'h0000, q);
  endtask
  // engine pulse; m = restart, page, fault, not-negotiating
  task automatic ev(input logic [3:0] m, input logic [15:0] w);
    @(posedge clk_sys) #1;
    {an_restart, page_rx, par_fault, partner_not_an} = m;
    page_word = w;
    @(posedge clk_sys) #1;
    {an_restart, page_rx, par_fault, partner_not_an} = 4'h0;
    page_word = ~w;
  endtask
  task automatic test_done;
    $display("comparisons %0d, mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic t_reset;
    rd(5'h04);
    `CHK(q, 16'h01E1)
    `CHK(adv_word, 16'h01E1)
    rd(5'h05);
    `CHK(q, 16'h0000)
    rd(5'h06);
    `CHK(q, 16'h0004)
    $display("reset test done");
  endtask
  task automatic t_adv;
    mdl.rmw(5'h04, 16'hFFFF);
    rd(5'h04);
    `CHK(q, 16'hA7E1)
    `CHK(adv_word, 16'hA7E1)
    mdl.rmw(5'h04, 16'h0000);
    `CHK(adv_word, 16'h0001)
    mdl.acc(1'b1, 5'h05, 16'hFFFF, q);
    rd(5'h05);
    `CHK(q, 16'h0000)
    rd(5'h1F);
    `CHK(q, 16'h0000)
    $display("advertisement test done");
  endtask
  task automatic t_page;
    `CHK(an_complete, 1'b0)
    ev(4'h4, 16'hFFFF);
    `CHK(an_complete, 1'b1)
    an_done_in = 1'b0;
    @(posedge clk_sys) #1;
    `CHK(an_complete, 1'b0)
    an_done_in = 1'b1;
    rd(5'h05);
    if (an_complete === 1'b1) `CHK(q, 16'hE7FF)
    rd(5'h06);
    `CHK(q, 16'h000F)
    rd(5'h06);
    `CHK(q, 16'h000D)
    ev(4'h8, 16'h0000);
    rd(5'h05);
    `CHK(q, 16'h0000)
    `CHK(an_complete, 1'b0)
    $display("page test done");
  endtask
  task automatic t_flags;
    ev(4'h2, 16'h0000);
    rd(5'h06);
    `CHK(q, 16'h0014)
    fork
      rd(5'h06);
      ev(4'h6, 16'h0000);
    join
    rd(5'h06);
    `CHK(q, 16'h0017)
    ev(4'h4, 16'h8000);
    ev(4'h1, 16'h0000);
    rd(5'h06);
    `CHK(q, 16'h000E)
    $display("flag test done");
  endtask
  // chip reset in mid-run restores defaults and drops every capture and flag
  task automatic t_rst;
    mdl.rmw(5'h04, 16'h0400);
    ev(4'h6, 16'hFFFF);
    `CHK(adv_word, 16'h0401)
    @(posedge clk_sys) #1 rst_n = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    `CHK(adv_word, 16'h01E1)
    `CHK(an_complete, 1'b0)
    rd(5'h05);
    `CHK(q, 16'h0000)
    rd(5'h06);
    `CHK(q, 16'h0004)
    $display("mid-run reset test done");
  endtask
  // watchdog, far beyond the fewer than a hundred cycles the tests take
  initial begin
    #100000;
    fails++;
    test_done;
  end
  // reset, then the scenarios
  initial begin
    rst_n = 1'b0;
    {an_restart, page_rx, par_fault, partner_not_an} = 4'h0;
    page_word = 16'h0000;
    an_done_in = 1'b1;
    repeat (20) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    t_reset;
    t_adv;
    t_page;
    t_flags;
    t_rst;
    test_done;
  end
endmodule // autoneg_ability_registers_test
